// ---- common/bew_pkg.sv ----
`default_nettype none
package bew_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_STATUS_LO = 8'h00;
    localparam logic [7:0] OFF_STATUS_HI = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_WDOG = 8'h14;
    // bit positions inside the 64-bit bank error status
    localparam int BIT_CODE10 = 10;
    localparam int BIT_CODE11 = 11;
    localparam int BIT_INIT_DRIVEN = 30;
    localparam int BIT_INIT_RECEIVED = 35;
    localparam int BIT_RESP_PARITY = 36;
    localparam int BIT_SPLIT_HARD = 37;
    localparam int BIT_RETIRE_TIMEOUT = 38;
    // interrupt status bit positions
    localparam int IRQ_INIT_DRIVEN = 0;
    localparam int IRQ_INIT_RECEIVED = 1;
    localparam int IRQ_RESP_PARITY = 2;
    localparam int IRQ_SPLIT_HARD = 3;
    localparam int IRQ_RETIRE_TIMEOUT = 4;
    localparam int IRQ_BITS = 5;
    // control register fields and reset values
    localparam int CTRL_DRIVER_EN = 0;
    localparam int CTRL_RATIO_LSB = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [63:0] STATUS_RESET = 64'h0;
    // watchdog timing
    localparam int PRESCALE_BITS = 8;
    localparam int PRESCALE_DIV = 128;
    localparam int WDOG_BITS = 15;
    // core-to-bus ratio codes
    localparam logic [1:0] RATIO_2 = 2'h0;
    localparam logic [1:0] RATIO_3 = 2'h1;
    localparam logic [1:0] RATIO_4 = 2'h2;
endpackage : bew_pkg
`default_nettype wire

// ---- hdl/bew_sync.sv ----
`default_nettype none
module bew_sync
    import bew_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout <= '0;
        end else if (clk_en) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : bew_sync
`default_nettype wire

// ---- hdl/bew_watchdog.sv ----
// Function
// - set status bit 30 when this device drives bus initialisation
// - set status bit 35 when bus initialisation is received from another agent
// - set status bit 36 on a parity error over the response status pins
// - responder drives parity pin; device checks status pins against it
// - set status bit 37 on hard error response to a split transaction
// - set status bit 38 on a retirement time-out
// - time-out is the carry out of the 15-bit watchdog counter
// - retire, exception, reset or retirement bus initialisation clear the counter; here bus initialisation does not, the time-out does
// - counter advances on each carry of the divide-by-128 8-bit prescaler
// - bus clock is core clock divided by 2, 3 or 4; prescaler counts bus clocks
// - once time-out bit is set, it and its logged data stay unchanged
// - on time-out error-code bit 10 is one, all other code bits zero
// - time-out reported only while the bus initialisation driver is enabled
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
module bew_watchdog
    import bew_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_init_drive,
    input wire logic bus_init_signal,
    input wire logic [2:0] response_status_pins,
    input wire logic response_parity_pin,
    input wire logic response_valid,
    input wire logic split_hard_error,
    input wire logic uop_retire,
    input wire logic core_exception,
    output logic retire_timeout,
    output logic irq
);
    logic [63:0] status_q;
    logic [31:0] ctrl_q;
    logic [IRQ_BITS-1:0] irq_stat_q;
    logic [IRQ_BITS-1:0] irq_mask_q;
    logic [PRESCALE_BITS-1:0] prescale_q;
    logic [1:0] ratio_cnt_q;
    logic [WDOG_BITS-1:0] wdog_q;
    logic init_rx_s;
    logic [2:0] rs_s;
    logic rsp_s;
    logic rsp_valid_s;
    logic bus_tick;
    logic pre_carry;
    logic wdog_carry;
    logic wdog_clear;
    logic timeout_evt;
    logic parity_err;
    logic wr_acc;
    logic [IRQ_BITS-1:0] events;
    logic [1:0] ratio_max;

    // external pins are resynchronised before use
    bew_sync #(.WIDTH(6)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .din({bus_init_signal, response_status_pins, response_parity_pin, response_valid}),
        .dout({init_rx_s, rs_s, rsp_s, rsp_valid_s})
    );

    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;

    // bus clock tick derived from core clock by the programmed ratio
    always_comb begin
        case (ctrl_q[CTRL_RATIO_LSB +: 2])
            RATIO_2: ratio_max = 2'd1;
            RATIO_3: ratio_max = 2'd2;
            default: ratio_max = 2'd3;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_cnt_q <= '0;
        end else if (clk_en) begin
            if (ratio_cnt_q >= ratio_max) begin
                ratio_cnt_q <= '0;
            end else begin
                ratio_cnt_q <= ratio_cnt_q + 2'd1;
            end
        end
    end
    assign bus_tick = (ratio_cnt_q >= ratio_max);

    // prescaler wraps every 128 bus clocks
    assign pre_carry = bus_tick && (prescale_q == PRESCALE_BITS'(PRESCALE_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q <= '0;
        end else if (clk_en && bus_tick) begin
            if (pre_carry) begin
                prescale_q <= '0;
            end else begin
                prescale_q <= prescale_q + 1'b1;
            end
        end
    end

    assign wdog_carry = pre_carry && (&wdog_q);
    assign timeout_evt = wdog_carry && ctrl_q[CTRL_DRIVER_EN];
    assign wdog_clear = uop_retire || core_exception || timeout_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_q <= '0;
        end else if (clk_en) begin
            if (wdog_clear) begin
                wdog_q <= '0;
            end else if (pre_carry) begin
                wdog_q <= wdog_q + 1'b1;
            end
        end
    end

    // even parity over the three status pins plus the parity pin
    assign parity_err = rsp_valid_s && ^{rs_s, rsp_s};

    assign events[IRQ_INIT_DRIVEN] = bus_init_drive;
    assign events[IRQ_INIT_RECEIVED] = init_rx_s;
    assign events[IRQ_RESP_PARITY] = parity_err;
    assign events[IRQ_SPLIT_HARD] = split_hard_error;
    assign events[IRQ_RETIRE_TIMEOUT] = timeout_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= STATUS_RESET;
        end else if (clk_en) begin
            if (timeout_evt && !status_q[BIT_RETIRE_TIMEOUT]) begin
                status_q[BIT_RETIRE_TIMEOUT] <= 1'b1;
                status_q[15:0] <= 16'h0400;
            end else if (!status_q[BIT_RETIRE_TIMEOUT]) begin
                if (wr_acc && paddr == OFF_STATUS_LO) begin
                    status_q[31:0] <= status_q[31:0] & pwdata;
                end else if (wr_acc && paddr == OFF_STATUS_HI) begin
                    status_q[63:32] <= status_q[63:32] & pwdata;
                end
                if (bus_init_drive) begin
                    status_q[BIT_INIT_DRIVEN] <= 1'b1;
                end
                if (init_rx_s) begin
                    status_q[BIT_INIT_RECEIVED] <= 1'b1;
                end
                if (parity_err) begin
                    status_q[BIT_RESP_PARITY] <= 1'b1;
                end
                if (split_hard_error) begin
                    status_q[BIT_SPLIT_HARD] <= 1'b1;
                    status_q[BIT_CODE11] <= 1'b1;
                end
            end else if (wr_acc && paddr == OFF_STATUS_HI && !pwdata[BIT_RETIRE_TIMEOUT-32]) begin
                // logged record frozen until software clears the time-out bit
                status_q <= STATUS_RESET;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= '0;
        end else if (clk_en && wr_acc) begin
            if (paddr == OFF_CTRL) begin
                ctrl_q <= pwdata;
            end else if (paddr == OFF_IRQ_MASK) begin
                irq_mask_q <= pwdata[IRQ_BITS-1:0];
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else if (clk_en) begin
            if (wr_acc && paddr == OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_BITS-1:0]) | events;
            end else begin
                irq_stat_q <= irq_stat_q | events;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            retire_timeout <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_stat_q & irq_mask_q);
            retire_timeout <= timeout_evt;
        end
    end

    always_comb begin
        pslverr = 1'b0;
        prdata = 32'h0;
        if (psel && !pwrite) begin
            if (paddr == OFF_STATUS_LO) begin
                prdata = status_q[31:0];
            end else if (paddr == OFF_STATUS_HI) begin
                prdata = status_q[63:32];
            end else if (paddr == OFF_CTRL) begin
                prdata = ctrl_q;
            end else if (paddr == OFF_IRQ_STAT) begin
                prdata = 32'(irq_stat_q);
            end else if (paddr == OFF_IRQ_MASK) begin
                prdata = 32'(irq_mask_q);
            end else if (paddr == OFF_WDOG) begin
                prdata = 32'(wdog_q);
            end else begin
                pslverr = psel && penable;
            end
        end else if (psel && penable && !(paddr == OFF_STATUS_LO || paddr == OFF_STATUS_HI
                || paddr == OFF_CTRL || paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK)) begin
            pslverr = 1'b1;
        end
    end

    // the prescaler must be wide enough for its divide ratio
    if (PRESCALE_DIV > (1 << PRESCALE_BITS) || WDOG_BITS < 1) begin : g_bad_sizes
        $error("prescaler or watchdog sizes unsupported");
    end

    // watchdog advance chain: bus tick, prescaler wrap, counter step
    sequence s_pre_wrap;
        bus_tick && prescale_q == 8'd127;
    endsequence
    sequence s_wdog_step;
        clk_en && !wdog_clear && pre_carry;
    endsequence
    sequence s_wdog_wrap;
        pre_carry && (&wdog_q);
    endsequence

    a_timeout_sets_bit: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && timeout_evt && !status_q[BIT_RETIRE_TIMEOUT] |=> status_q[BIT_RETIRE_TIMEOUT])
        else $error("time-out did not set status bit");
    a_timeout_code: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(status_q[BIT_RETIRE_TIMEOUT]) |-> status_q[15:0] == 16'h0400)
        else $error("error code wrong after time-out");
    a_code_held: assert property (@(posedge pclk) disable iff (!presetn)
        status_q[BIT_RETIRE_TIMEOUT] |-> status_q[15:0] == 16'h0400)
        else $error("error code changed while time-out logged");
    a_timeout_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        status_q[BIT_RETIRE_TIMEOUT] && !wr_acc |=> $stable(status_q))
        else $error("frozen record changed");
    a_frozen_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
        status_q[BIT_RETIRE_TIMEOUT] && wr_acc && paddr == OFF_STATUS_LO |=> $stable(status_q))
        else $error("frozen record overwritten");
    a_frozen_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && status_q[BIT_RETIRE_TIMEOUT] && wr_acc && paddr == OFF_STATUS_HI
        && !pwdata[BIT_RETIRE_TIMEOUT-32] |=> status_q == STATUS_RESET)
        else $error("time-out record not cleared");
    a_driver_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[CTRL_DRIVER_EN] |-> !timeout_evt)
        else $error("time-out reported with driver disabled");
    a_carry_reports: assert property (@(posedge pclk) disable iff (!presetn)
        s_wdog_wrap ##0 ctrl_q[CTRL_DRIVER_EN] |-> timeout_evt)
        else $error("enabled carry not reported");
    a_wdog_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && (uop_retire || core_exception) |=> wdog_q == '0)
        else $error("watchdog not cleared");
    a_wdog_evt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && timeout_evt |=> wdog_q == '0)
        else $error("watchdog not cleared by time-out");
    a_carry_at_max: assert property (@(posedge pclk) disable iff (!presetn)
        wdog_carry |-> wdog_q == {WDOG_BITS{1'b1}} && prescale_q == 8'd127)
        else $error("carry at wrong count");
    a_timeout_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && timeout_evt |=> retire_timeout)
        else $error("time-out pulse missing");
    a_timeout_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(retire_timeout) |-> $past(timeout_evt))
        else $error("time-out pulse without carry");
    a_prescale_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        prescale_q <= 8'd127)
        else $error("prescaler past 127");
    a_pre_carry_seen: assert property (@(posedge pclk) disable iff (!presetn)
        s_pre_wrap |-> pre_carry)
        else $error("prescaler wrap without carry");
    a_wdog_step: assert property (@(posedge pclk) disable iff (!presetn)
        s_wdog_step |=> wdog_q == $past(wdog_q) + 1'b1)
        else $error("watchdog did not step");
    a_wdog_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !wdog_clear && !pre_carry |=> $stable(wdog_q))
        else $error("watchdog moved without carry");
    a_prescale_step: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bus_tick && !pre_carry |=> prescale_q == $past(prescale_q) + 1'b1)
        else $error("prescaler did not step");
    a_prescale_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !bus_tick |=> $stable(prescale_q))
        else $error("prescaler moved without bus tick");
    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bus_tick |=> !bus_tick)
        else $error("bus tick faster than half core clock");
    a_parity_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !rsp_valid_s |-> !parity_err)
        else $error("parity error outside a response");
    a_parity_flag: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && parity_err && !status_q[BIT_RETIRE_TIMEOUT] && !timeout_evt
        |=> status_q[BIT_RESP_PARITY])
        else $error("parity error not logged");
    a_init_flags: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bus_init_drive && !status_q[BIT_RETIRE_TIMEOUT] && !timeout_evt
        |=> status_q[BIT_INIT_DRIVEN])
        else $error("driven init not logged");
    a_init_rx_flag: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && init_rx_s && !status_q[BIT_RETIRE_TIMEOUT] && !timeout_evt
        |=> status_q[BIT_INIT_RECEIVED])
        else $error("received init not logged");
    a_split_flag: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && split_hard_error && !status_q[BIT_RETIRE_TIMEOUT] && !timeout_evt
        |=> status_q[BIT_SPLIT_HARD] && status_q[BIT_CODE11])
        else $error("split hard error not logged");
    a_sw_clear_lo: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_acc && paddr == OFF_STATUS_LO && !status_q[BIT_RETIRE_TIMEOUT]
        && !timeout_evt && !bus_init_drive && !split_hard_error
        |=> status_q[31:0] == ($past(status_q[31:0]) & $past(pwdata)))
        else $error("low status clear wrong");
    a_sw_clear_hi: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_acc && paddr == OFF_STATUS_HI && !status_q[BIT_RETIRE_TIMEOUT]
        && !timeout_evt && !init_rx_s && !parity_err && !split_hard_error
        |=> status_q[63:32] == ($past(status_q[63:32]) & $past(pwdata)))
        else $error("high status clear wrong");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> irq == $past(|(irq_stat_q & irq_mask_q)))
        else $error("interrupt level wrong");
    a_irq_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && (|events) |=> (irq_stat_q & $past(events)) == $past(events))
        else $error("interrupt event lost");
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_acc && paddr == OFF_CTRL |=> ctrl_q == $past(pwdata))
        else $error("control write lost");
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_acc && paddr == OFF_IRQ_MASK |=> irq_mask_q == $past(pwdata[IRQ_BITS-1:0]))
        else $error("mask write lost");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr == 8'h18 |-> pslverr)
        else $error("unmapped access without error");
endmodule : bew_watchdog
`default_nettype wire

// ---- tb/bew_bus_agent.sv ----
`default_nettype none
module bew_bus_agent (
    input wire logic pclk,
    input wire logic send,
    input wire logic bad_parity,
    input wire logic [2:0] status,
    input wire logic init_req,
    output logic [2:0] response_status_pins,
    output logic response_parity_pin,
    output logic response_valid,
    output logic bus_init_signal
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        response_status_pins = 3'h0;
        response_parity_pin = 1'b0;
        response_valid = 1'b0;
        bus_init_signal = 1'b0;
    end
    always @(posedge pclk) begin
        response_valid <= send;
        bus_init_signal <= init_req;
        if (send) begin
            response_status_pins <= status;
            response_parity_pin <= (^status) ^ bad_parity;
        end else begin
            // released lines show the inverse of their last value
            response_status_pins <= ~response_status_pins;
            response_parity_pin <= ~response_parity_pin;
        end
    end
endmodule : bew_bus_agent
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb
    import bew_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, retire_timeout;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv, rng, e;
    logic errv, bus_init_drive, split_hard_error, uop_retire, core_exception;
    logic ag_send, ag_bad, ag_init, bus_init_signal, response_parity_pin, response_valid;
    logic [2:0] ag_rs, response_status_pins;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2 pclk = ~pclk;
    bew_watchdog i_bew_watchdog (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_init_drive(bus_init_drive),
        .bus_init_signal(bus_init_signal), .response_status_pins(response_status_pins),
        .response_parity_pin(response_parity_pin), .response_valid(response_valid),
        .split_hard_error(split_hard_error), .uop_retire(uop_retire),
        .core_exception(core_exception), .retire_timeout(retire_timeout), .irq(irq));
    bew_bus_agent i_bew_bus_agent (.pclk(pclk), .send(ag_send), .bad_parity(ag_bad),
        .status(ag_rs), .init_req(ag_init), .response_status_pins(response_status_pins),
        .response_parity_pin(response_parity_pin), .response_valid(response_valid),
        .bus_init_signal(bus_init_signal));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    function automatic logic [31:0] wd_exp(input int k, input int t);
        return t / (PRESCALE_DIV * (k + 2));
    endfunction : wd_exp
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic pulse(input int sel);
        {core_exception, uop_retire, split_hard_error, bus_init_drive} <= 4'h1 << sel;
        @(posedge pclk);
        {core_exception, uop_retire, split_hard_error, bus_init_drive} <= 4'h0;
        repeat (4) @(posedge pclk);
    endtask : pulse
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bus_init_drive, split_hard_error, uop_retire, core_exception} = 4'h0;
        {ag_send, ag_bad, ag_init, ag_rs} = '0;
        rng = 32'h8e71;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFF_STATUS_LO, 0);
        chk("status lo", rdv, STATUS_RESET[31:0]);
        apb(0, OFF_STATUS_HI, 0);
        chk("status hi", rdv, STATUS_RESET[63:32]);
        apb(0, OFF_CTRL, 0);
        chk("ctrl", rdv, CTRL_RESET);
        apb(0, OFF_IRQ_STAT, 0);
        chk("irq stat", rdv, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test reset done");
        apb(1, OFF_IRQ_MASK, 32'h1f);
        pulse(0);
        apb(0, OFF_STATUS_LO, 0);
        chk("init driven", {31'h0, rdv[BIT_INIT_DRIVEN]}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        ag_init <= 1'b1;
        repeat (2) @(posedge pclk);
        ag_init <= 1'b0;
        pulse(1);
        apb(0, OFF_STATUS_HI, 0);
        chk("init received", {31'h0, rdv[BIT_INIT_RECEIVED-32]}, 32'h1);
        chk("split hard", {31'h0, rdv[BIT_SPLIT_HARD-32]}, 32'h1);
        apb(0, OFF_IRQ_STAT, 0);
        e = (1 << IRQ_INIT_DRIVEN) | (1 << IRQ_INIT_RECEIVED) | (1 << IRQ_SPLIT_HARD);
        chk("irq stat", rdv, e);
        apb(1, OFF_STATUS_HI, 0);
        apb(1, OFF_STATUS_LO, 0);
        apb(0, OFF_STATUS_HI, 0);
        chk("status hi cleared", rdv, 32'h0);
        apb(0, OFF_STATUS_LO, 0);
        chk("status lo cleared", rdv, 32'h0);
        apb(1, OFF_IRQ_MASK, 0);
        apb(1, OFF_IRQ_STAT, 32'h1f);
        pulse(1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1, OFF_IRQ_MASK, 1 << IRQ_SPLIT_HARD);
        @(posedge pclk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        apb(1, OFF_IRQ_STAT, 32'h1f);
        apb(0, OFF_IRQ_STAT, 0);
        chk("irq stat w1c", rdv, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("test events done");
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            apb(1, OFF_STATUS_HI, 0);
            ag_send <= 1'b1;
            ag_rs <= rng[2:0];
            ag_bad <= (i < 2) ? i[0] : rng[3];
            @(posedge pclk);
            ag_send <= 1'b0;
            repeat (6) @(posedge pclk);
            apb(0, OFF_STATUS_HI, 0);
            chk("parity flag", {31'h0, rdv[BIT_RESP_PARITY-32]}, {31'h0, ag_bad});
        end
        $display("test parity done");
        apb(0, 8'h18, 0);
        chk("unmapped err", {31'h0, errv}, 32'h1);
        chk("unmapped data", rdv, 32'h0);
        apb(1, OFF_WDOG, 32'h5);
        chk("wdog write err", {31'h0, errv}, 32'h1);
        rng = xs(rng);
        apb(1, OFF_IRQ_MASK, rng);
        apb(0, OFF_IRQ_MASK, 0);
        chk("mask readback", rdv, rng & 32'h1f);
        $display("test apb done");
        for (int k = 0; k < 3; k++) begin
            apb(1, OFF_CTRL, (k << CTRL_RATIO_LSB) | 1);
            pulse(2);
            apb(0, OFF_WDOG, 0);
            chk("wdog after retire", {31'h0, (rdv <= 1)}, 32'h1);
            repeat (1000) @(posedge pclk);
            apb(0, OFF_WDOG, 0);
            e = wd_exp(k, 1010);
            chk("wdog count", {31'h0, (rdv + 1 >= e && rdv <= e + 1)}, 32'h1);
            pulse(3);
            apb(0, OFF_WDOG, 0);
            chk("wdog after exception", {31'h0, (rdv <= 1)}, 32'h1);
        end
        chk("retire timeout", {31'h0, retire_timeout}, 32'h0);
        $display("test watchdog done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
